// [rtl/pmc_pkg.sv]
// Shared constants and types of the supply control register bank
package pmc_pkg;

  // Register offsets on the serial port
  localparam logic [7:0] PMC_OFS_REV  = 8'h00;
  localparam logic [7:0] PMC_OFS_STAT = 8'h01;
  localparam logic [7:0] PMC_OFS_MASK = 8'h02;
  localparam logic [7:0] PMC_OFS_EN   = 8'h03;
  localparam logic [7:0] PMC_OFS_MODE = 8'h04;

  // Revision code; arbitrary value
  localparam logic [7:0] PMC_REV_CODE = 8'h5A;

  // Reset values and read value of holes in the map
  localparam logic [7:0] PMC_MASK_RST = 8'hC0;
  localparam logic [7:0] PMC_EN_RST   = 8'hFF;
  localparam logic [7:0] PMC_MODE_RST = 8'hB0;
  localparam logic [7:0] PMC_UNMAPPED = 8'hFF;

  // Implemented bits of status and enable registers
  localparam logic [7:0] PMC_STAT_USED = 8'hFE;
  localparam logic [7:0] PMC_EN_USED   = 8'h3E;

  // Serial slave address and byte length
  localparam logic [6:0] PMC_SLAVE_ADDR = 7'h48;
  localparam logic [3:0] PMC_BYTE_BITS  = 4'h8;

  // Bit positions shared by status, mask and enable registers
  localparam int PMC_B_PFAIL  = 7;
  localparam int PMC_B_LOWBAT = 6;
  localparam int PMC_B_BUCKA  = 5;
  localparam int PMC_B_BUCKB  = 4;
  localparam int PMC_B_CORE   = 3;
  localparam int PMC_B_LIN2   = 2;
  localparam int PMC_B_LIN1   = 1;
  localparam int PMC_B_RAMP   = 0;  // Ramp flag rides the unused status slot in the sync vector

  // Converter mode field positions
  localparam int PMC_M_PHB_HI = 7;
  localparam int PMC_M_PHB_LO = 6;
  localparam int PMC_M_PHC_HI = 5;
  localparam int PMC_M_PHC_LO = 4;
  localparam int PMC_M_RIPPLE = 3;
  localparam int PMC_M_FFP_B  = 2;
  localparam int PMC_M_FFP_A  = 1;
  localparam int PMC_M_FFP_C  = 0;

  // Serial link states
  typedef enum logic [3:0] {
    PMC_L_IDLE,
    PMC_L_ADDR,
    PMC_L_ADDR_ACK,
    PMC_L_PTR,
    PMC_L_PTR_ACK,
    PMC_L_WDATA,
    PMC_L_WDATA_ACK,
    PMC_L_RDATA,
    PMC_L_RD_ACK
  } pmc_link_state_t;

endpackage

// [rtl/pmc_i2c_link.sv]
// Serial slave engine on the link clock, handing register accesses over by toggle
module pmc_i2c_link (
  // Link clock and reset
  input  wire logic       link_clk,
  input  wire logic       link_rst_b,
  // Serial pins
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_drv_en,
  // Register access handshake
  output logic            req_tgl,
  output logic            req_wr,
  output logic [7:0]      req_addr,
  output logic [7:0]      req_wdata,
  input  wire logic       ack_tgl,
  input  wire logic [7:0] rd_data
);
  import pmc_pkg::*;

  // Whole link state
  typedef struct packed {
    logic [1:0]      scl_s;     // Pin synchroniser
    logic [1:0]      sda_s;     // Pin synchroniser
    logic [1:0]      ack_s;     // Acknowledge toggle synchroniser
    logic            scl_d;     // Previous synced clock level
    logic            sda_d;     // Previous synced data level
    pmc_link_state_t st;        // Protocol state
    logic [3:0]      bits;      // Bits moved in current byte
    logic [7:0]      shift;     // Byte shifter
    logic [7:0]      ptr;       // Register pointer
    logic            rw;        // Read transfer
    logic            rd_wait;   // Read answer outstanding
    logic            oe;        // Pull data low
    logic            req_tgl;   // Request toggle
    logic            req_wr;    // Request is a write
    logic [7:0]      req_addr;  // Request offset
    logic [7:0]      req_wdata; // Request write data
  } pmc_link_t;

  pmc_link_t r_reg;
  pmc_link_t r_next;
  logic      scl_h;    // Synced clock
  logic      sda_h;    // Synced data
  logic      pending;  // Request not yet answered
  logic      rise_c;   // Clock rising
  logic      fall_c;   // Clock falling
  logic      start_c;  // Start condition
  logic      stop_c;   // Stop condition

  // One-cycle edge of a level
  function automatic logic pmc_edge(input logic now_l, input logic was_l);
    return now_l & ~was_l;
  endfunction

  // Launch a register access; fields stay put until the answer toggles back
  function automatic pmc_link_t pmc_issue(input pmc_link_t s, input logic wr, input logic [7:0] d);
    pmc_link_t n;
    n = s;
    n.req_tgl   = ~s.req_tgl;
    n.req_wr    = wr;
    n.req_addr  = s.ptr;
    n.req_wdata = d;
    n.rd_wait   = ~wr;
    if (wr) begin
      n.ptr = s.ptr + 8'h01;
    end
    return n;
  endfunction

  // Protocol next state
  always_comb begin
    r_next   = r_reg;
    scl_h    = r_reg.scl_s[1];
    sda_h    = r_reg.sda_s[1];
    pending  = r_reg.req_tgl ^ r_reg.ack_s[1];
    rise_c   = pmc_edge(scl_h, r_reg.scl_d);
    fall_c   = pmc_edge(r_reg.scl_d, scl_h);
    start_c  = scl_h & r_reg.scl_d & pmc_edge(r_reg.sda_d, sda_h);
    stop_c   = scl_h & r_reg.scl_d & pmc_edge(sda_h, r_reg.sda_d);
    r_next.scl_s = {r_reg.scl_s[0], scl};
    r_next.sda_s = {r_reg.sda_s[0], sda};
    r_next.ack_s = {r_reg.ack_s[0], ack_tgl};
    r_next.scl_d = scl_h;
    r_next.sda_d = sda_h;
    // Read answer arrived: load shifter, pointer moves on
    if (r_reg.rd_wait && !pending) begin
      r_next.shift   = rd_data;
      r_next.rd_wait = 1'b0;
      r_next.ptr     = r_reg.ptr + 8'h01;
    end
    if (start_c) begin
      r_next.st   = PMC_L_ADDR;
      r_next.bits = 4'h0;
      r_next.oe   = 1'b0;
    end else if (stop_c) begin
      r_next.st = PMC_L_IDLE;
      r_next.oe = 1'b0;
    end else begin
      case (r_reg.st)
        // Receiving a byte
        PMC_L_ADDR, PMC_L_PTR, PMC_L_WDATA: begin
          if (rise_c) begin
            r_next.shift = {r_reg.shift[6:0], sda_h};
            r_next.bits  = r_reg.bits + 4'h1;
          end else if (fall_c && r_reg.bits == PMC_BYTE_BITS) begin
            r_next.bits = 4'h0;
            r_next.oe   = 1'b1;
            if (r_reg.st == PMC_L_ADDR) begin
              if (r_reg.shift[7:1] == PMC_SLAVE_ADDR) begin
                r_next.rw = r_reg.shift[0];
                r_next.st = PMC_L_ADDR_ACK;
                // Fetch early: the first data bit is due at the end of the acknowledge
                if (r_reg.shift[0] && !pending) begin
                  r_next = pmc_issue(r_next, 1'b0, r_reg.shift);
                end
              end else begin
                r_next.oe = 1'b0;
                r_next.st = PMC_L_IDLE;
              end
            end else if (r_reg.st == PMC_L_PTR) begin
              r_next.ptr = r_reg.shift;
              r_next.st  = PMC_L_PTR_ACK;
            end else begin
              if (!pending) begin
                r_next = pmc_issue(r_next, 1'b1, r_reg.shift);
              end
              r_next.st = PMC_L_WDATA_ACK;
            end
          end
        end
        // Our acknowledge bit ends on the falling clock
        PMC_L_ADDR_ACK, PMC_L_PTR_ACK, PMC_L_WDATA_ACK: begin
          if (fall_c) begin
            r_next.oe = 1'b0;
            if (r_reg.st == PMC_L_ADDR_ACK && r_reg.rw) begin
              r_next.st   = PMC_L_RDATA;
              r_next.oe   = ~r_next.shift[7];
              r_next.bits = 4'h1;
            end else if (r_reg.st == PMC_L_ADDR_ACK) begin
              r_next.st = PMC_L_PTR;
            end else begin
              r_next.st = PMC_L_WDATA;
            end
          end
        end
        // Sending a byte, MSB first
        PMC_L_RDATA: begin
          if (fall_c) begin
            if (r_reg.bits == PMC_BYTE_BITS) begin
              r_next.oe   = 1'b0;
              r_next.st   = PMC_L_RD_ACK;
              r_next.bits = 4'h0;
            end else begin
              r_next.oe    = ~r_reg.shift[6];
              r_next.shift = {r_reg.shift[6:0], 1'b1};
              r_next.bits  = r_reg.bits + 4'h1;
            end
          end
        end
        // Master acknowledge: low asks for another byte
        PMC_L_RD_ACK: begin
          if (rise_c) begin
            if (!sda_h && !pending) begin
              r_next = pmc_issue(r_next, 1'b0, r_reg.shift);
            end else if (sda_h) begin
              r_next.st = PMC_L_IDLE;
            end
          end else if (fall_c) begin
            r_next.st   = PMC_L_RDATA;
            r_next.oe   = ~r_next.shift[7];
            r_next.bits = 4'h1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Link state register
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      r_reg       <= '0;
      // Idle bus is high: no false edge seen after reset
      r_reg.scl_s <= 2'h3;
      r_reg.sda_s <= 2'h3;
      r_reg.scl_d <= 1'b1;
      r_reg.sda_d <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sda_drv_en = r_reg.oe;
  assign req_tgl    = r_reg.req_tgl;
  assign req_wr     = r_reg.req_wr;
  assign req_addr   = r_reg.req_addr;
  assign req_wdata  = r_reg.req_wdata;

endmodule

// [rtl/pmc_supply_regs.sv]
// Supply control and status register bank with its serial slave
module pmc_supply_regs (
  // Clocks and resets
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       link_clk,
  input  wire logic       link_rst_b,
  // Serial pins, open drain data
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_drv,
  output logic            sda_drv_en,
  // Comparator levels, asynchronous
  input  wire logic       power_fail_sense,
  input  wire logic       low_battery_sense,
  input  wire logic       buck_rail_a_low,
  input  wire logic       buck_rail_b_low,
  input  wire logic       core_buck_rail_low,
  input  wire logic       linear_reg_two_low,
  input  wire logic       linear_reg_one_low,
  input  wire logic       core_voltage_ramp,
  // Enable pins, asynchronous
  input  wire logic       buck_a_enable_pin,
  input  wire logic       buck_b_enable_pin,
  input  wire logic       core_buck_enable_pin,
  input  wire logic       linear_enable_pin,
  // Supply enables
  output logic            buck_rail_a_en,
  output logic            buck_rail_b_en,
  output logic            core_buck_rail_en,
  output logic            linear_reg_two_en,
  output logic            linear_reg_one_en,
  // Converter mode
  output logic [1:0]      buck_b_phase,
  output logic [1:0]      core_buck_phase,
  output logic            low_ripple_skip,
  output logic            buck_a_forced_fixed_pwm,
  output logic            buck_b_forced_fixed_pwm,
  output logic            core_buck_forced_fixed_pwm,
  // Interrupt, active low
  output logic            irq_b
);
  import pmc_pkg::*;

  // Whole register bank state
  typedef struct packed {
    logic [7:0] low_s1;     // Comparator sync, first stage
    logic [7:0] low_s2;     // Comparator sync, second stage
    logic [7:0] pin_s1;     // Enable pin sync, first stage
    logic [7:0] pin_s2;     // Enable pin sync, second stage
    logic [1:0] req_s;      // Request toggle sync
    logic       req_d;      // Last request toggle served
    logic       ack_tgl;    // Answer toggle to link
    logic [7:0] rd_data;    // Read answer, held for link
    logic [7:0] mask;       // Interrupt mask
    logic [7:0] enreg;      // Supply enable control
    logic [7:0] mode;       // Converter mode control
    logic [7:0] block;      // Bits blocked by a status read
    logic [7:0] supply_en;  // Registered supply enables
    logic       irq_b;      // Interrupt, active low
  } pmc_bank_t;

  pmc_bank_t  r_reg;
  pmc_bank_t  r_next;
  logic [7:0] low_in;        // Comparators packed in status order
  logic [7:0] pin_in;        // Pins packed in enable order
  logic [7:0] en_eff;        // Supplies actually enabled
  logic [7:0] stat_live;     // Live status value
  logic [7:0] active;        // Status bits reaching the interrupt
  logic       req_seen;      // New request from the link
  logic       link_req_tgl;  // Link request toggle
  logic       link_req_wr;   // Link request is a write
  logic [7:0] link_req_addr; // Link request offset
  logic [7:0] link_req_wd;   // Link request write data

  // Serial engine on the link clock
  pmc_i2c_link u_link (
    .link_clk   (link_clk),
    .link_rst_b (link_rst_b),
    .scl        (scl),
    .sda        (sda),
    .sda_drv_en (sda_drv_en),
    .req_tgl    (link_req_tgl),
    .req_wr     (link_req_wr),
    .req_addr   (link_req_addr),
    .req_wdata  (link_req_wd),
    .ack_tgl    (r_reg.ack_tgl),
    .rd_data    (r_reg.rd_data)
  );

  // Pin packing, read only by the first sync stage
  always_comb begin
    low_in               = 8'h00;
    low_in[PMC_B_PFAIL]  = power_fail_sense;
    low_in[PMC_B_LOWBAT] = low_battery_sense;
    low_in[PMC_B_BUCKA]  = buck_rail_a_low;
    low_in[PMC_B_BUCKB]  = buck_rail_b_low;
    low_in[PMC_B_CORE]   = core_buck_rail_low;
    low_in[PMC_B_LIN2]   = linear_reg_two_low;
    low_in[PMC_B_LIN1]   = linear_reg_one_low;
    low_in[PMC_B_RAMP]   = core_voltage_ramp;
    pin_in               = 8'hFF;
    pin_in[PMC_B_BUCKA]  = buck_a_enable_pin;
    pin_in[PMC_B_BUCKB]  = buck_b_enable_pin;
    pin_in[PMC_B_CORE]   = core_buck_enable_pin;
    // One pin serves both linear regulators
    pin_in[PMC_B_LIN2]   = linear_enable_pin;
    pin_in[PMC_B_LIN1]   = linear_enable_pin;
  end

  // Bank next state
  always_comb begin
    r_next        = r_reg;
    r_next.low_s1 = low_in;
    r_next.low_s2 = r_reg.low_s1;
    r_next.pin_s1 = pin_in;
    r_next.pin_s2 = r_reg.pin_s1;
    r_next.req_s  = {r_reg.req_s[0], link_req_tgl};
    req_seen      = r_reg.req_s[1] ^ r_reg.req_d;
    // Pin and register bit must both allow a supply
    en_eff = r_reg.pin_s2 & r_reg.enreg & PMC_EN_USED;
    // Live status; disabled rails never report low
    stat_live               = 8'h00;
    stat_live[PMC_B_PFAIL]  = r_reg.low_s2[PMC_B_PFAIL];
    stat_live[PMC_B_LOWBAT] = r_reg.low_s2[PMC_B_LOWBAT];
    stat_live[PMC_B_BUCKA]  = r_reg.low_s2[PMC_B_BUCKA] & en_eff[PMC_B_BUCKA];
    stat_live[PMC_B_BUCKB]  = r_reg.low_s2[PMC_B_BUCKB] & en_eff[PMC_B_BUCKB];
    // Core rail is expected out of range while it ramps
    stat_live[PMC_B_CORE]   = r_reg.low_s2[PMC_B_CORE] & en_eff[PMC_B_CORE] & ~r_reg.low_s2[PMC_B_RAMP];
    stat_live[PMC_B_LIN2]   = r_reg.low_s2[PMC_B_LIN2] & en_eff[PMC_B_LIN2];
    stat_live[PMC_B_LIN1]   = r_reg.low_s2[PMC_B_LIN1] & en_eff[PMC_B_LIN1];
    // Interrupt sources that are neither masked nor blocked
    active       = stat_live & ~r_reg.mask & ~r_reg.block;
    r_next.irq_b = ~|active;
    // A block lasts while its bit stays active
    r_next.block = r_reg.block & stat_live;
    // Serve one access per link request
    if (req_seen) begin
      r_next.req_d   = r_reg.req_s[1];
      r_next.ack_tgl = ~r_reg.ack_tgl;
      if (link_req_wr) begin
        case (link_req_addr)
          PMC_OFS_MASK: begin
            r_next.mask = link_req_wd;
          end
          PMC_OFS_EN: begin
            r_next.enreg = (link_req_wd & PMC_EN_USED) | ~PMC_EN_USED;
          end
          PMC_OFS_MODE: begin
            r_next.mode = link_req_wd;
          end
          // Revision, status and holes take no write
          default: begin
          end
        endcase
      end else begin
        case (link_req_addr)
          PMC_OFS_REV: begin
            r_next.rd_data = PMC_REV_CODE;
          end
          PMC_OFS_STAT: begin
            r_next.rd_data = stat_live;
            r_next.block   = r_reg.block | stat_live;
          end
          PMC_OFS_MASK: begin
            r_next.rd_data = r_reg.mask;
          end
          PMC_OFS_EN: begin
            r_next.rd_data = r_reg.enreg;
          end
          PMC_OFS_MODE: begin
            r_next.rd_data = r_reg.mode;
          end
          default: begin
            r_next.rd_data = PMC_UNMAPPED;
          end
        endcase
      end
    end
    // A low pin wins over a write in the same cycle
    r_next.enreg     = r_next.enreg | (~r_reg.pin_s2 & PMC_EN_USED);
    r_next.supply_en = r_reg.pin_s2 & r_next.enreg & PMC_EN_USED;
  end

  // Bank register; reset stands for undervoltage lockout
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r_reg       <= '0;
      r_reg.mask  <= PMC_MASK_RST;
      r_reg.enreg <= PMC_EN_RST;
      r_reg.mode  <= PMC_MODE_RST;
      r_reg.irq_b <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the bank register; data drive is tied low
  assign sda_drv                    = 1'b0;
  assign buck_rail_a_en             = r_reg.supply_en[PMC_B_BUCKA];
  assign buck_rail_b_en             = r_reg.supply_en[PMC_B_BUCKB];
  assign core_buck_rail_en          = r_reg.supply_en[PMC_B_CORE];
  assign linear_reg_two_en          = r_reg.supply_en[PMC_B_LIN2];
  assign linear_reg_one_en          = r_reg.supply_en[PMC_B_LIN1];
  assign buck_b_phase               = r_reg.mode[PMC_M_PHB_HI:PMC_M_PHB_LO];
  assign core_buck_phase            = r_reg.mode[PMC_M_PHC_HI:PMC_M_PHC_LO];
  assign low_ripple_skip            = r_reg.mode[PMC_M_RIPPLE];
  assign buck_b_forced_fixed_pwm    = r_reg.mode[PMC_M_FFP_B];
  assign buck_a_forced_fixed_pwm    = r_reg.mode[PMC_M_FFP_A];
  assign core_buck_forced_fixed_pwm = r_reg.mode[PMC_M_FFP_C];
  assign irq_b                      = r_reg.irq_b;

  // Checks on the bank, all in the system clock domain
  default clocking pmc_cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Read and write requests of one offset
  sequence rd_req_s(logic [7:0] ofs);
    req_seen && !link_req_wr && link_req_addr == ofs;
  endsequence
  sequence wr_req_s(logic [7:0] ofs);
    req_seen && link_req_wr && link_req_addr == ofs;
  endsequence

  rev_read_a: assert property (rd_req_s(PMC_OFS_REV) |=> r_reg.rd_data == PMC_REV_CODE)
    else $error("revision read wrong");
  rev_nowrite_a: assert property (wr_req_s(PMC_OFS_REV) |=> $stable(r_reg.mask) && $stable(r_reg.mode))
    else $error("revision write changed state");
  stat_read_a: assert property (rd_req_s(PMC_OFS_STAT) |=> r_reg.rd_data == ($past(stat_live) & PMC_STAT_USED))
    else $error("status read wrong");
  pfail_flag_a: assert property ($rose(r_reg.low_s2[PMC_B_PFAIL]) |-> stat_live[PMC_B_PFAIL])
    else $error("power fail flag not shown");
  rail_off_a: assert property (!(r_reg.pin_s2[PMC_B_BUCKA] && r_reg.enreg[PMC_B_BUCKA])
    |-> !stat_live[PMC_B_BUCKA])
    else $error("disabled buck A reports low");
  ramp_hide_a: assert property (r_reg.low_s2[PMC_B_RAMP] |-> !stat_live[PMC_B_CORE])
    else $error("core low shown during ramp");
  lin_off_a: assert property (!r_reg.pin_s2[PMC_B_LIN1] |-> !stat_live[PMC_B_LIN1] && !stat_live[PMC_B_LIN2])
    else $error("disabled linear reports low");
  irq_mask_a: assert property ((stat_live & ~r_reg.mask & ~r_reg.block) == 8'h00 |=> r_reg.irq_b)
    else $error("masked status drove interrupt");
  irq_assert_a: assert property (|(stat_live & ~r_reg.mask & ~r_reg.block) |=> !irq_b)
    else $error("interrupt not asserted");
  reset_vals_a: assert property (@(posedge clk) disable iff (1'b0)
    !rst_b |=> r_reg.mask == PMC_MASK_RST && r_reg.enreg == PMC_EN_RST && r_reg.mode == PMC_MODE_RST)
    else $error("register reset values wrong");
  pin_default_a: assert property (!r_reg.pin_s2[PMC_B_CORE] |=> r_reg.enreg[PMC_B_CORE])
    else $error("enable bit not restored");
  en_combine_a: assert property (##1
    r_reg.supply_en == ($past(r_reg.pin_s2) & r_reg.enreg & PMC_EN_USED))
    else $error("supply enable combine wrong");
  mode_write_a: assert property (wr_req_s(PMC_OFS_MODE) |=> low_ripple_skip == $past(link_req_wd[PMC_M_RIPPLE]))
    else $error("mode write not applied");
  hole_read_a: assert property (req_seen && !link_req_wr && link_req_addr > PMC_OFS_MODE
    |=> r_reg.rd_data == PMC_UNMAPPED)
    else $error("unmapped read not FFh");
  read_block_a: assert property (rd_req_s(PMC_OFS_STAT) |=> (r_reg.block & $past(stat_live)) == $past(stat_live))
    else $error("status read did not block");
  unused_en_a: assert property (wr_req_s(PMC_OFS_EN) |=> (r_reg.enreg & ~PMC_EN_USED) == ~PMC_EN_USED)
    else $error("unused enable bits changed");

endmodule

// [tb/pmc_host_model.sv]
// Serial host model: drives the clock pin and releases or pulls data
module pmc_host_model (
  // Clock
  input  wire logic clk,
  // Wire level
  input  wire logic sda,
  // Host pins, data 1 = released
  output logic      scl,
  output logic      sda_out
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int Q = 28;  // Quarter bit, 700 ns
  initial begin
    scl = 1'b1;
    sda_out = 1'b1;
  end
  // Wait n quarter bits
  task automatic w(input int n);
    repeat (n * Q) @(posedge clk);
  endtask
  // Start, also repeated start from a low clock
  task automatic start();
    w(1);
    sda_out <= 1'b1;
    w(1);
    scl <= 1'b1;
    w(2);
    sda_out <= 1'b0;
    w(2);
    scl <= 1'b0;
  endtask
  // Stop, then bus free time
  task automatic stop();
    w(1);
    sda_out <= 1'b0;
    w(1);
    scl <= 1'b1;
    w(2);
    sda_out <= 1'b1;
    w(2);
  endtask
  // Data moves only while the clock is low
  task automatic bit_x(input logic b, output logic s);
    w(1);
    sda_out <= b;
    w(1);
    scl <= 1'b1;
    w(2);
    s = sda;
    scl <= 1'b0;
  endtask
  // Byte MSB first, then acknowledge slot
  task automatic xfer(input logic [7:0] b, input logic a, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) bit_x(b[i], r[i]);
    bit_x(a, k);
  endtask
endmodule

// [tb/tb_top.sv]
// Bench for the supply register bank through its serial port
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pmc_pkg::*;
  logic       clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       rst_b = 1'b0;  // Lockout stand-in
  logic [7:0] sen = 8'h00;   // Comparators, ramp in bit 0
  logic [3:0] pin = 4'hF;    // Pins a, b, core, linear
  wire  [4:0] en;            // Supply enables
  wire  [7:0] md;            // Mode outputs in register order
  logic [7:0] rb;
  logic       scl, m_sda, sda_drv, sda_drv_en, irq_b, k;
  wire        sda = m_sda & (sda_drv_en ? sda_drv : 1'b1);  // Pull-up
  int         error_cnt = 0;
  int         n_tests = 0;
  always #12.5 clk = ~clk;
  // Link clock, unrelated phase
  initial begin
    #3;
    forever #62.5 link_clk = ~link_clk;
  end
  pmc_supply_regs dut_u (.clk, .rst_b, .link_clk, .link_rst_b(rst_b), .scl, .sda, .sda_drv, .sda_drv_en,
    .power_fail_sense(sen[7]), .low_battery_sense(sen[6]), .buck_rail_a_low(sen[5]),
    .buck_rail_b_low(sen[4]), .core_buck_rail_low(sen[3]), .linear_reg_two_low(sen[2]),
    .linear_reg_one_low(sen[1]), .core_voltage_ramp(sen[0]), .buck_a_enable_pin(pin[3]),
    .buck_b_enable_pin(pin[2]), .core_buck_enable_pin(pin[1]), .linear_enable_pin(pin[0]),
    .buck_rail_a_en(en[4]), .buck_rail_b_en(en[3]), .core_buck_rail_en(en[2]),
    .linear_reg_two_en(en[1]), .linear_reg_one_en(en[0]), .buck_b_phase(md[7:6]),
    .core_buck_phase(md[5:4]), .low_ripple_skip(md[3]), .buck_b_forced_fixed_pwm(md[2]),
    .buck_a_forced_fixed_pwm(md[1]), .core_buck_forced_fixed_pwm(md[0]), .irq_b);
  pmc_host_model m_u (.clk, .sda, .scl, .sda_out(m_sda));
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Pointer write, then data byte or repeated start and one read byte
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    m_u.start();
    m_u.xfer(8'h90, 1'b1, rb, k);
    cmp("addr ack", 8'h00, {7'h00, k});
    m_u.xfer(a, 1'b1, rb, k);
    if (w) m_u.xfer(d, 1'b1, rb, k);
    else begin
      m_u.start();
      m_u.xfer(8'h91, 1'b1, rb, k);
      m_u.xfer(8'hFF, 1'b1, rb, k);  // Host NACK ends the read
    end
    m_u.stop();
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
    acc(1'b0, a, 8'h00);
    cmp(n, e, rb);
  endtask
  task automatic chk_irq(input logic e, input string n);
    repeat (10) @(posedge clk);
    cmp(n, {7'h00, e}, {7'h00, irq_b});
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog over the whole sequence
  initial begin
    repeat (95000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (20) @(posedge clk);
    rc(8'h00, PMC_REV_CODE, "revision");
    rc(8'h02, 8'hC0, "mask rst");
    rc(8'h03, 8'hFF, "enable rst");
    rc(8'h04, 8'hB0, "mode rst");
    cmp("mode rst pins", 8'hB0, md);
    rc(8'h07, 8'hFF, "hole");
    chk_irq(1'b1, "irq idle");
    $display("reset test done");
    acc(1'b1, 8'h04, 8'h5A);
    chk_irq(1'b1, "irq mode");
    cmp("mode pins", 8'h5A, md);
    rc(8'h04, 8'h5A, "mode rb");
    acc(1'b1, 8'h04, 8'hA5);
    cmp("mode pins inv", 8'hA5, md);
    acc(1'b1, 8'h00, 8'h00);
    rc(8'h00, PMC_REV_CODE, "rev rb");
    m_u.start();
    m_u.xfer(8'h92, 1'b1, rb, k);
    m_u.stop();
    cmp("bad addr", 8'h01, {7'h00, k});
    $display("mode test done");
    acc(1'b1, 8'h03, 8'h00);
    cmp("en off", 8'h00, {3'h0, en});
    rc(8'h03, 8'hC1, "en rb");
    pin <= 4'hE;
    repeat (10) @(posedge clk);
    pin <= 4'hF;
    chk_irq(1'b1, "irq pin");
    cmp("en lin", 8'h03, {3'h0, en});
    $display("enable test done");
    sen <= 8'hA9;  // Fail flag, rail a low but off, core low but off and ramping
    chk_irq(1'b1, "irq dis");
    rc(8'h01, 8'h80, "stat dis");
    sen <= 8'h28;
    acc(1'b1, 8'h03, 8'hFF);
    chk_irq(1'b0, "irq on");
    rc(8'h01, 8'h28, "stat on");
    chk_irq(1'b1, "irq blk");
    acc(1'b1, 8'h02, 8'h80);
    sen <= 8'h68;
    chk_irq(1'b0, "irq lowbat");
    sen <= 8'hA8;
    chk_irq(1'b1, "irq masked");
    sen <= 8'h09;  // Core enabled and low, but ramping
    rc(8'h01, 8'h00, "stat ramp");
    $display("status test done");
    print_verdict();
  end
endmodule
